// ==== hdl/uis_params.svh ====
// Named constants of the USB to I2C slave bridge data path
`ifndef UIS_PARAMS_SVH
`define UIS_PARAMS_SVH
`define UIS_DATA_W 8
`define UIS_FIFO_DEPTH 512
`define UIS_CLK_HZ 25000000
`define UIS_I2C_HS_HZ 3400000
`define UIS_I2C_ADDR 7'h22
`define UIS_BYTE_BITS 4'h8
`define UIS_LAST_BIT 4'h7
`define UIS_MAX_PKT 64
`define UIS_CRC_INIT 16'hFFFF
`define UIS_CRC_POLY 16'hA001
`define UIS_CRC_RESID 16'hB001
`define UIS_NPINS 6
`define UIS_FN_W 3
`define UIS_DIV_W 16
`define UIS_DIV_RESET 16'h0019
`define UIS_LINE_W 2
`define UIS_IDLE_BYTE 8'hFF
`endif

// ==== hdl/uis_pkg.sv ====
// Types shared by the bridge data path modules
package uis_pkg;
   // Serial line operating modes
   typedef enum logic [1:0] {UIS_MODE_I2C, UIS_MODE_ASYNC, UIS_MODE_SYNC} uis_mode_t;
   // Functions selectable per control pin
   typedef enum logic [2:0]
   {
      UIS_FN_TRISTATE,
      UIS_FN_DRIVE1,
      UIS_FN_DRIVE0,
      UIS_FN_WR_STROBE,
      UIS_FN_RD_STROBE,
      UIS_FN_EMPTY_N,
      UIS_FN_FULL_N
   } uis_pin_fn_t;
   // Serial slave states
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK}
      uis_sl_state_t;
endpackage

// ==== hdl/uis_stream_if.sv ====
// Byte stream carrier with valid and ready
`include "uis_params.svh"
interface uis_stream_if #(parameter int W = `UIS_DATA_W);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== hdl/uis_fifo.sv ====
// Flip-flop FIFO with honest full and empty
`include "uis_params.svh"
module uis_fifo #(
   parameter int W = `UIS_DATA_W,
   parameter int DEPTH = `UIS_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Stream sides
   uis_stream_if.snk push,
   uis_stream_if.src pop,
   // Fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic do_push, do_pop;

   // Full blocks the producer so unread bytes are never overwritten
   assign level = wr_ptr_reg - rd_ptr_reg;
   assign push.ready = (level != (AW + 1)'(DEPTH));
   assign pop.valid = (level != '0);
   assign pop.data = mem_reg[rd_ptr_reg[AW-1:0]];
   assign do_push = push.valid & push.ready;
   assign do_pop = pop.valid & pop.ready;

   // Pointer advance
   always_comb
   begin
      wr_ptr_next = do_push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
   end

   // Pointer registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
      end
   end

   // Storage has no reset; contents are only read behind the pointers
   always_ff @(posedge clk)
   begin
      if (do_push)
         mem_reg[wr_ptr_reg[AW-1:0]] <= push.data;
   end
endmodule // uis_fifo

// ==== hdl/uis_i2c_slave.sv ====
// Serial slave shift engine for the two-wire bus
`include "uis_params.svh"
module uis_i2c_slave #(
   parameter logic [6:0] ADDR = `UIS_I2C_ADDR
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Synchronised lines and enable
   input wire logic enable,
   input wire logic scl,
   input wire logic sda,
   output logic sda_low,
   // Byte streams
   uis_stream_if.snk tx_src,
   uis_stream_if.src rx_dst
);
   uis_pkg::uis_sl_state_t st_reg, st_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   logic scl_d_reg, sda_d_reg, low_reg, low_next, ack_reg, ack_next, push_reg, push_next;
   logic rise, fall, start, stop;

   assign rise = scl & ~scl_d_reg;
   assign fall = ~scl & scl_d_reg;
   assign start = scl & scl_d_reg & sda_d_reg & ~sda;
   assign stop = scl & scl_d_reg & ~sda_d_reg & sda;
   assign sda_low = low_reg;
   assign rx_dst.valid = push_reg;
   assign rx_dst.data = sh_reg;

   // Bus sequencing; bits sampled on rising clock, driven after falling
   always_comb
   begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      low_next = low_reg;
      ack_next = ack_reg;
      push_next = 1'b0;
      tx_src.ready = 1'b0;
      if (!enable || stop)
      begin
         st_next = uis_pkg::S_IDLE;
         low_next = 1'b0;
      end
      else if (start)
      begin
         st_next = uis_pkg::S_ADDR;
         cnt_next = '0;
         low_next = 1'b0;
      end
      else
      begin
         unique case (st_reg)
            uis_pkg::S_IDLE: ;
            uis_pkg::S_ADDR, uis_pkg::S_WR:
            begin
               if (rise)
               begin
                  sh_next = {sh_reg[6:0], sda};
                  cnt_next = cnt_reg + 1'b1;
               end
               else if (fall && cnt_reg == `UIS_BYTE_BITS)
               begin
                  if (st_reg == uis_pkg::S_ADDR)
                  begin
                     low_next = (sh_reg[7:1] == ADDR);
                     st_next = low_next ? uis_pkg::S_ADDR_ACK : uis_pkg::S_IDLE;
                  end
                  else if (rx_dst.ready)
                  begin
                     push_next = 1'b1;
                     low_next = 1'b1;
                     st_next = uis_pkg::S_WR_ACK;
                  end
                  else
                  begin
                     low_next = 1'b0;
                     st_next = uis_pkg::S_IDLE;
                  end
               end
            end
            uis_pkg::S_WR_ACK:
            begin
               if (fall)
               begin
                  low_next = 1'b0;
                  cnt_next = '0;
                  st_next = uis_pkg::S_WR;
               end
            end
            uis_pkg::S_ADDR_ACK, uis_pkg::S_RD_ACK:
            begin
               if (rise)
                  ack_next = ~sda;
               if (fall)
               begin
                  if ((st_reg == uis_pkg::S_ADDR_ACK && !sh_reg[0]))
                  begin
                     low_next = 1'b0;
                     cnt_next = '0;
                     st_next = uis_pkg::S_WR;
                  end
                  else if (st_reg == uis_pkg::S_ADDR_ACK || ack_reg)
                  begin
                     // Empty buffer answers with idle bytes
                     tx_src.ready = tx_src.valid;
                     sh_next = tx_src.valid ? tx_src.data : `UIS_IDLE_BYTE;
                     low_next = ~sh_next[7];
                     cnt_next = '0;
                     st_next = uis_pkg::S_RD;
                  end
                  else
                  begin
                     low_next = 1'b0;
                     st_next = uis_pkg::S_IDLE;
                  end
               end
            end
            uis_pkg::S_RD:
            begin
               if (fall)
               begin
                  if (cnt_reg == `UIS_LAST_BIT)
                  begin
                     low_next = 1'b0;
                     st_next = uis_pkg::S_RD_ACK;
                  end
                  else
                  begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     low_next = ~sh_reg[6];
                     cnt_next = cnt_reg + 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Slave state registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= uis_pkg::S_IDLE;
         cnt_reg <= '0;
         sh_reg <= '0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         low_reg <= 1'b0;
         ack_reg <= 1'b0;
         push_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         scl_d_reg <= scl;
         sda_d_reg <= sda;
         low_reg <= low_next;
         ack_reg <= ack_next;
         push_reg <= push_next;
      end
   end
endmodule // uis_i2c_slave

// ==== hdl/uis_top.sv ====
// Top of the USB to I2C slave bridge data path
`include "uis_params.svh"
module uis_top #(
   parameter int FIFO_DEPTH = `UIS_FIFO_DEPTH,
   parameter logic [6:0] I2C_ADDR = `UIS_I2C_ADDR,
   parameter int MAX_PKT = `UIS_MAX_PKT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Bulk OUT byte stream
   input wire logic usb_out_valid,
   input wire logic [7:0] usb_out_data,
   input wire logic usb_out_last,
   output logic usb_out_ready,
   output logic usb_out_crc_err,
   // Bulk IN byte stream
   input wire logic usb_in_req,
   input wire logic usb_in_ready,
   output logic usb_in_valid,
   output logic [7:0] usb_in_data,
   output logic usb_in_last,
   output logic usb_in_zlp,
   output logic [15:0] usb_in_crc,
   // Vendor command settings
   input wire logic cfg_wr,
   input wire logic [1:0] cfg_mode,
   input wire logic [`UIS_DIV_W-1:0] cfg_div,
   input wire logic [`UIS_LINE_W-1:0] cfg_dir,
   // Stored control pin settings
   input wire logic [`UIS_NPINS*`UIS_FN_W-1:0] pin_fn_cfg,
   input wire logic [`UIS_NPINS-1:0] pin_drive_cfg,
   // Serial lines, bit 0 clock, bit 1 data
   input wire logic [`UIS_LINE_W-1:0] line_i,
   output logic [`UIS_LINE_W-1:0] line_o,
   output logic [`UIS_LINE_W-1:0] line_oe_n,
   // Control pins
   output logic [`UIS_NPINS-1:0] pin_o,
   output logic [`UIS_NPINS-1:0] pin_oe_n,
   output logic [`UIS_NPINS-1:0] pin_drive_hi
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   // ********************************************************
   // Streams and FIFOs
   // ********************************************************
   uis_stream_if #(.W(`UIS_DATA_W)) rx_push ();
   uis_stream_if #(.W(`UIS_DATA_W)) rx_pop ();
   uis_stream_if #(.W(`UIS_DATA_W)) tx_push ();
   uis_stream_if #(.W(`UIS_DATA_W)) tx_pop ();
   uis_stream_if #(.W(`UIS_DATA_W)) sl_rx ();
   uis_stream_if #(.W(`UIS_DATA_W)) sl_tx ();
   logic [LW-1:0] rx_level, tx_level;

   // Both FIFOs and all control run on the single core clock
   uis_fifo #(.W(`UIS_DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(core_clk),
      .rst_n(rst_n),
      .push(rx_push),
      .pop(rx_pop),
      .level(rx_level)
   );

   uis_fifo #(.W(`UIS_DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(core_clk),
      .rst_n(rst_n),
      .push(tx_push),
      .pop(tx_pop),
      .level(tx_level)
   );

   // ********************************************************
   // Settings and line synchroniser
   // ********************************************************
   uis_pkg::uis_mode_t mode_reg, mode_next;
   logic [`UIS_DIV_W-1:0] div_reg, div_next;
   logic [`UIS_LINE_W-1:0] dir_reg, dir_next, sync1_reg, line_s_reg;
   logic bb_mode;

   // Settings change only on a vendor command write
   always_comb
   begin
      mode_next = cfg_wr ? uis_pkg::uis_mode_t'(cfg_mode) : mode_reg;
      div_next = cfg_wr ? cfg_div : div_reg;
      dir_next = cfg_wr ? cfg_dir : dir_reg;
   end

   // Settings and two-flop line synchroniser; reset from rst_n only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_reg <= uis_pkg::UIS_MODE_I2C;
         div_reg <= `UIS_DIV_RESET;
         dir_reg <= '0;
         sync1_reg <= '1;
         line_s_reg <= '1;
      end
      else
      begin
         mode_reg <= mode_next;
         div_reg <= div_next;
         dir_reg <= dir_next;
         sync1_reg <= line_i;
         line_s_reg <= sync1_reg;
      end
   end

   assign bb_mode = (mode_reg != uis_pkg::UIS_MODE_I2C);

   // ********************************************************
   // Serial slave
   // ********************************************************
   logic sda_low;

   uis_i2c_slave #(.ADDR(I2C_ADDR)) u_slave (
      .clk(core_clk),
      .rst_n(rst_n),
      .enable(~bb_mode),
      .scl(line_s_reg[0]),
      .sda(line_s_reg[1]),
      .sda_low(sda_low),
      .tx_src(sl_rx),
      .rx_dst(sl_tx)
   );

   // ********************************************************
   // Bit-bang port
   // ********************************************************
   logic [`UIS_DIV_W-1:0] tick_cnt_reg, tick_cnt_next;
   logic [`UIS_LINE_W-1:0] bb_out_reg, bb_out_next;
   logic [7:0] bb_smp_reg, bb_smp_next;
   logic bb_push_reg, bb_push_next, wr_stb_n_reg, wr_stb_n_next, rd_stb_n_reg, rd_stb_n_next;
   logic tick, bb_pop;

   // Divider of the core clock stands in for the baud prescaler
   assign tick = bb_mode && (tick_cnt_reg == '0);

   // Port pacing, writes and samples
   always_comb
   begin
      tick_cnt_next = tick_cnt_reg;
      bb_out_next = bb_out_reg;
      bb_smp_next = bb_smp_reg;
      bb_push_next = 1'b0;
      wr_stb_n_next = 1'b1;
      rd_stb_n_next = 1'b1;
      bb_pop = 1'b0;
      if (bb_mode)
         tick_cnt_next = tick ? div_reg : tick_cnt_reg - 1'b1;
      if (tick && mode_reg == uis_pkg::UIS_MODE_ASYNC)
      begin
         if (rx_pop.valid)
         begin
            bb_pop = 1'b1;
            bb_out_next = rx_pop.data[`UIS_LINE_W-1:0];
            wr_stb_n_next = 1'b0;
         end
         if (tx_push.ready)
         begin
            bb_smp_next = {6'h00, line_s_reg};
            bb_push_next = 1'b1;
            rd_stb_n_next = 1'b0;
         end
      end
      else if (tick && mode_reg == uis_pkg::UIS_MODE_SYNC && rx_pop.valid && tx_push.ready)
      begin
         // Sample before the new value lands, so each reply shows the lines as they were before its byte
         bb_pop = 1'b1;
         bb_out_next = rx_pop.data[`UIS_LINE_W-1:0];
         bb_smp_next = {6'h00, line_s_reg};
         bb_push_next = 1'b1;
         wr_stb_n_next = 1'b0;
         rd_stb_n_next = 1'b0;
      end
   end

   // Bit-bang registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_reg <= '0;
         bb_out_reg <= '1;
         bb_smp_reg <= '0;
         bb_push_reg <= 1'b0;
         wr_stb_n_reg <= 1'b1;
         rd_stb_n_reg <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_next;
         bb_out_reg <= bb_out_next;
         bb_smp_reg <= bb_smp_next;
         bb_push_reg <= bb_push_next;
         wr_stb_n_reg <= wr_stb_n_next;
         rd_stb_n_reg <= rd_stb_n_next;
      end
   end

   // Line drive: open-drain data in slave mode, direction mask in port mode
   assign line_o = bb_mode ? bb_out_reg : '0;
   assign line_oe_n = bb_mode ? ~dir_reg : {~sda_low, 1'b1};

   // FIFO ports shared between slave and bit-bang port
   assign rx_pop.ready = bb_mode ? bb_pop : sl_rx.ready;
   assign sl_rx.valid = rx_pop.valid & ~bb_mode;
   assign sl_rx.data = rx_pop.data;
   assign tx_push.valid = bb_mode ? bb_push_reg : sl_tx.valid;
   assign tx_push.data = bb_mode ? bb_smp_reg : sl_tx.data;
   assign sl_tx.ready = tx_push.ready & ~bb_mode;

   // ********************************************************
   // USB side streams and CRC
   // ********************************************************
   logic [15:0] out_crc_reg, out_crc_next, in_crc_reg, in_crc_next;
   logic crc_err_reg, crc_err_next, in_busy_reg, in_busy_next, zlp_reg, zlp_next;
   logic [6:0] in_cnt_reg, in_cnt_next;
   logic out_take, in_take;

   // One byte through the reflected CRC16 divider
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ `UIS_CRC_POLY) : (r >> 1);
      return r;
   endfunction

   // Recovered OUT bytes are accepted only while the FIFO has room
   assign rx_push.valid = usb_out_valid;
   assign rx_push.data = usb_out_data;
   assign usb_out_ready = rx_push.ready;
   assign out_take = usb_out_valid & rx_push.ready;

   // IN answers stream straight out of the transmit FIFO
   assign usb_in_valid = in_busy_reg & tx_pop.valid;
   assign usb_in_data = tx_pop.data;
   assign usb_in_last = usb_in_valid
      && ((in_cnt_reg == 7'(MAX_PKT - 1)) || (tx_level == LW'(1)));
   assign tx_pop.ready = in_busy_reg & usb_in_ready;
   assign in_take = usb_in_valid & usb_in_ready;
   assign usb_out_crc_err = crc_err_reg;
   assign usb_in_crc = in_crc_reg;
   assign usb_in_zlp = zlp_reg;

   // Packet CRC check, IN CRC generation and IN packet framing
   always_comb
   begin
      out_crc_next = out_crc_reg;
      crc_err_next = 1'b0;
      in_crc_next = in_crc_reg;
      in_busy_next = in_busy_reg;
      in_cnt_next = in_cnt_reg;
      zlp_next = 1'b0;
      if (out_take)
      begin
         out_crc_next = crc16_byte(out_crc_reg, usb_out_data);
         if (usb_out_last)
         begin
            crc_err_next = (out_crc_next != `UIS_CRC_RESID);
            out_crc_next = `UIS_CRC_INIT;
         end
      end
      if (usb_in_req && !in_busy_reg)
      begin
         in_crc_next = `UIS_CRC_INIT;
         in_cnt_next = '0;
         in_busy_next = tx_pop.valid;
         zlp_next = ~tx_pop.valid;
      end
      else if (in_take)
      begin
         in_crc_next = crc16_byte(in_crc_reg, tx_pop.data);
         in_cnt_next = in_cnt_reg + 1'b1;
         in_busy_next = ~usb_in_last;
      end
   end

   // USB side registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_crc_reg <= `UIS_CRC_INIT;
         crc_err_reg <= 1'b0;
         in_crc_reg <= `UIS_CRC_INIT;
         in_busy_reg <= 1'b0;
         in_cnt_reg <= '0;
         zlp_reg <= 1'b0;
      end
      else
      begin
         out_crc_reg <= out_crc_next;
         crc_err_reg <= crc_err_next;
         in_crc_reg <= in_crc_next;
         in_busy_reg <= in_busy_next;
         in_cnt_reg <= in_cnt_next;
         zlp_reg <= zlp_next;
      end
   end

   // ********************************************************
   // Control pins
   // ********************************************************
   for (genvar p = 0; p < `UIS_NPINS; p++)
   begin : g_pin
      uis_pkg::uis_pin_fn_t fn;
      logic o_reg, o_next, oe_n_reg, oe_n_next, drv_reg;
      assign fn = uis_pkg::uis_pin_fn_t'(pin_fn_cfg[p*`UIS_FN_W +: `UIS_FN_W]);

      // Pin function decode from stored settings
      always_comb
      begin
         oe_n_next = 1'b0;
         unique case (fn)
            uis_pkg::UIS_FN_TRISTATE:
            begin
               o_next = 1'b0;
               oe_n_next = 1'b1;
            end
            uis_pkg::UIS_FN_DRIVE1: o_next = 1'b1;
            uis_pkg::UIS_FN_DRIVE0: o_next = 1'b0;
            uis_pkg::UIS_FN_WR_STROBE: o_next = wr_stb_n_reg;
            uis_pkg::UIS_FN_RD_STROBE: o_next = rd_stb_n_reg;
            uis_pkg::UIS_FN_EMPTY_N: o_next = rx_pop.valid;
            uis_pkg::UIS_FN_FULL_N: o_next = tx_push.ready;
            default:
            begin
               o_next = 1'b0;
               oe_n_next = 1'b1;
            end
         endcase
      end

      // Pin output flops; strobes appear two cycles after the tick that causes them
      always_ff @(posedge core_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            o_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            drv_reg <= 1'b0;
         end
         else
         begin
            o_reg <= o_next;
            oe_n_reg <= oe_n_next;
            drv_reg <= pin_drive_cfg[p];
         end
      end

      assign pin_o[p] = o_reg;
      assign pin_oe_n[p] = oe_n_reg;
      assign pin_drive_hi[p] = drv_reg;
   end
endmodule // uis_top

// ==== verif/uis_top_properties.sv ====
// Port properties of the bridge data path top
module uis_top_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Host streams
   input wire logic usb_out_valid,
   input wire logic usb_out_ready,
   input wire logic usb_out_last,
   input wire logic usb_out_crc_err,
   input wire logic usb_in_req,
   input wire logic usb_in_valid,
   input wire logic usb_in_last,
   input wire logic usb_in_zlp,
   input wire logic [15:0] usb_in_crc,
   // Control pins
   input wire logic [17:0] pin_fn_cfg,
   input wire logic [5:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Checks
   // ****
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   out_holdoff_a: assert property ($fell(usb_out_ready) |-> $past(usb_out_valid))
      else $error("ready fell untaken");
   crc_flag_a: assert property (usb_out_crc_err |->
      $past(usb_out_valid && usb_out_ready && usb_out_last)) else $error("stray crc flag");
   in_start_a: assert property ($rose(usb_in_valid) |-> $past(usb_in_req))
      else $error("unrequested data");
   zlp_cause_a: assert property (usb_in_zlp |-> $past(usb_in_req) && !usb_in_valid)
      else $error("stray empty packet");
   crc_restart_a: assert property ($past(usb_in_req && !usb_in_valid) |->
      usb_in_crc == 16'hFFFF) else $error("crc not restarted");
   in_last_a: assert property (usb_in_last |-> usb_in_valid)
      else $error("last without data");
   // Strobes are single-cycle low pulses unless the divider setting is zero
   strobe_width_a: assert property (pin_fn_cfg[2:0] == 3'h3 && $fell(pin_o[0]) |=> pin_o[0])
      else $error("strobe too long");
   empty_flag_a: assert property ($rose(pin_o[1]) |->
      $past(usb_out_valid && usb_out_ready, 2)) else $error("empty flag early");
   cover property (usb_in_zlp);
   cover property (usb_out_crc_err);
   cover property (!usb_out_ready);
endmodule // uis_top_properties

bind uis_top uis_top_properties i_uis_top_properties (.*);

// ==== verif/uis_i2c_mst.sv ====
// Two-wire bus master model on open-drain lines
module uis_i2c_mst (
   // Line pull-downs
   output logic scl_low,
   output logic sda_low,
   // Resolved data line
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Bus cycles
   // ****
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic start();
      sda_low = 1'b1;
      #200 scl_low = 1'b1;
      #80;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #200 scl_low = 1'b0;
      #200 sda_low = 1'b0;
      #200;
   endtask
   // Halves of 200 ns keep each level over five core cycles
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      #200 scl_low = 1'b0;
      #200 r = sda;
      scl_low = 1'b1;
      #80; // Keeps every line change on a falling core edge
   endtask
   // Eight bits first-high, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
      output logic r);
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], q[i]);
      end
      bit_io(a, r);
   endtask
endmodule // uis_i2c_mst

// ==== verif/tb.sv ====
// Self-checking bench of the bridge data path
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic usb_out_valid = 1'b0;
   logic [7:0] usb_out_data = 8'h00;
   logic usb_out_last = 1'b0;
   logic usb_in_req = 1'b0;
   logic usb_in_ready = 1'b0;
   logic cfg_wr = 1'b0;
   logic [1:0] cfg_mode = 2'h0;
   logic [15:0] cfg_div = 16'h0007;
   logic [1:0] cfg_dir = 2'h0;
   logic [17:0] pin_fn_cfg = 18'h00C6B;
   logic [5:0] pin_drive_cfg = 6'h15;
   logic usb_out_ready, usb_out_crc_err, usb_in_valid, usb_in_last, usb_in_zlp, ack;
   logic [7:0] usb_in_data, q;
   logic [15:0] usb_in_crc;
   logic [1:0] line_o, line_oe_n, line_i;
   logic [5:0] pin_o, pin_oe_n, pin_drive_hi;
   logic m_scl, m_sda;
   logic crc_seen = 1'b0;
   logic zlp_seen = 1'b0;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   // ****
   // Bench top
   // ****
   // Pull-ups win unless someone drives
   assign line_i[0] = !line_oe_n[0] ? line_o[0] : !m_scl;
   assign line_i[1] = !line_oe_n[1] ? line_o[1] : !m_sda;
   uis_top #(.FIFO_DEPTH(4)) i_uis_top (.*);
   uis_i2c_mst i_uis_i2c_mst (.scl_low(m_scl), .sda_low(m_sda), .sda(line_i[1]));
   initial
   begin
      forever #20 core_clk = !core_clk;
   end
   // Watchdog and catchers for one-cycle pulses
   always @(negedge core_clk)
   begin
      cyc++;
      if (usb_out_crc_err === 1'b1) crc_seen = 1'b1;
      if (usb_in_zlp === 1'b1) zlp_seen = 1'b1;
      if (cyc == 20000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cfg(input logic [1:0] m, input logic [1:0] d);
      @(negedge core_clk);
      cfg_mode = m;
      cfg_dir = d;
      cfg_wr = 1'b1;
      @(negedge core_clk);
      cfg_wr = 1'b0;
   endtask
   // Byte held until the fifo has room
   task automatic push(input logic [7:0] d, input logic l);
      @(negedge core_clk);
      usb_out_valid = 1'b1;
      usb_out_data = d;
      usb_out_last = l;
      while (usb_out_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      usb_out_valid = 1'b0;
   endtask
   task automatic req();
      @(negedge core_clk);
      usb_in_req = 1'b1;
      @(negedge core_clk);
      usb_in_req = 1'b0;
   endtask
   task automatic get(input logic [7:0] d, input logic l);
      @(negedge core_clk);
      while (usb_in_valid !== 1'b1) @(negedge core_clk);
      chk(usb_in_data, d);
      chk(usb_in_last, l);
      usb_in_ready = 1'b1;
      @(negedge core_clk);
      usb_in_ready = 1'b0;
   endtask
   task automatic t_reset();
      repeat (3) @(negedge core_clk);
      chk(line_oe_n, 2'b11);
      chk(usb_in_crc, 16'hFFFF);
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      chk(pin_o[3:0], 4'hD);
      chk(pin_oe_n, 6'h30);
      chk(pin_drive_hi, 6'h15);
   endtask
   // Samples taken before each update come back in order
   task automatic t_sync();
      cfg(2'h2, 2'b01);
      push(8'h00, 1'b0);
      push(8'h01, 1'b0);
      repeat (24) @(negedge core_clk);
      chk(line_oe_n, 2'b10);
      req();
      get(8'h03, 1'b0);
      get(8'h02, 1'b1);
   endtask
   // Async port applies every queued byte in turn; idle samples fill the reply fifo
   task automatic t_async();
      cfg(2'h1, 2'b11);
      push(8'h02, 1'b0);
      repeat (48) @(negedge core_clk);
      chk(line_o, 2'b10);
      chk(line_oe_n, 2'b00);
      chk(pin_o[3], 1'b0);
   endtask
   task automatic t_i2c_wr();
      cfg(2'h0, 2'b00);
      i_uis_i2c_mst.start();
      i_uis_i2c_mst.xfer(8'h46, 1'b1, q, ack);
      chk(ack, 1'b1);
      i_uis_i2c_mst.stop();
      i_uis_i2c_mst.start();
      i_uis_i2c_mst.xfer(8'h44, 1'b1, q, ack);
      i_uis_i2c_mst.xfer(8'hA5, 1'b1, q, ack);
      chk(ack, 1'b0);
      i_uis_i2c_mst.xfer(8'h3C, 1'b1, q, ack);
      i_uis_i2c_mst.stop();
      req();
      get(8'hA5, 1'b0);
      get(8'h3C, 1'b1);
   endtask
   task automatic t_i2c_rd();
      push(8'h5A, 1'b1);
      repeat (3) @(negedge core_clk);
      chk(crc_seen, 1'b1);
      chk(pin_o[1], 1'b1);
      i_uis_i2c_mst.start();
      i_uis_i2c_mst.xfer(8'h45, 1'b1, q, ack);
      i_uis_i2c_mst.xfer(8'hFF, 1'b0, q, ack);
      chk(q, 8'h5A);
      i_uis_i2c_mst.xfer(8'hFF, 1'b1, q, ack);
      chk(q, 8'hFF);
      i_uis_i2c_mst.stop();
      chk(pin_o[1], 1'b0);
   endtask
   task automatic t_full();
      for (int i = 0; i < 4; i++) push(8'(i), 1'b0);
      chk(usb_out_ready, 1'b0);
      req();
      repeat (2) @(negedge core_clk);
      chk(zlp_seen, 1'b1);
   endtask
   initial
   begin
      t_reset();
      t_sync();
      t_i2c_wr();
      t_i2c_rd();
      t_full();
      t_async();
      report_and_stop();
   end
endmodule // tb
